// ===== hdl/apm_pkg.sv
// package: register map, field positions and mode encodings of the pin mux
package apm_pkg;
    localparam int unsigned ADDR_W           = 32;
    localparam int unsigned DATA_W           = 32;
    localparam logic [31:0] CFG_ADDR         = 32'h8093_0080;
    localparam int unsigned I2S_AUDIO_BIT    = 6;
    localparam int unsigned I2S_SERIAL_BIT   = 7;
    localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_I2S_AUDIO,
        MODE_I2S_SERIAL,
        MODE_UNDEFINED
    } apm_mode_t;
endpackage

// ===== hdl/apm_route_if.sv
// interface: selected mode passed from register slave to router
`timescale 1ns/100ps
`default_nettype none
interface apm_route_if;
    import apm_pkg::*;
    apm_mode_t mode;
    modport cfg (output mode);
    modport rtr (input mode);
endinterface
`default_nettype wire

// ===== hdl/apm_axi_regs.sv
// module: axi4-lite slave holding the device configuration register
`timescale 1ns/100ps
`default_nettype none
module apm_axi_regs
    import apm_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               codec_reset_n_pin_n,
    // write channels
    input  wire logic [ADDR_W-1:0]  awaddr,
    input  wire logic               awvalid,
    output var  logic               awready,
    input  wire logic [DATA_W-1:0]  wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output var  logic               wready,
    output var  logic [1:0]         bresp,
    output var  logic               bvalid,
    input  wire logic               bready,
    // read channels
    input  wire logic [ADDR_W-1:0]  araddr,
    input  wire logic               arvalid,
    output var  logic               arready,
    output var  logic [DATA_W-1:0]  rdata,
    output var  logic [1:0]         rresp,
    output var  logic               rvalid,
    input  wire logic               rready,
    // mode to router
    apm_route_if.cfg                route
);
    logic [ADDR_W-1:0] awAddr_r;
    logic              awHeld_r;
    logic [DATA_W-1:0] wData_r;
    logic [3:0]        wStrb_r;
    logic              wHeld_r;
    logic [1:0]        cfgBits_r;
    logic              awReady_r;
    logic              wReady_r;
    logic              arReady_r;

    wire awTake   = awvalid & awready;
    wire wTake    = wvalid & wready;
    wire doWrite  = awHeld_r & wHeld_r & ~bvalid;
    wire wrHit    = (awAddr_r[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2]);
    wire rdHit    = (araddr[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2]);
    wire arTake   = arvalid & arready;
    wire [DATA_W-1:0] cfgWord = {24'h00_0000, cfgBits_r, 6'h00};

    // ready flags are flops so every bus output leaves the block registered
    assign awready = awReady_r;
    assign wready  = wReady_r;
    assign arready = arReady_r;

    // two mode bits decode to one of four modes
    always_comb begin
        unique case (cfgBits_r)
            2'b00:   route.mode = MODE_NORMAL;
            2'b01:   route.mode = MODE_I2S_AUDIO;
            2'b10:   route.mode = MODE_I2S_SERIAL;
            default: route.mode = MODE_UNDEFINED;
        endcase
    end

    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            awAddr_r <= '0;
            awHeld_r <= 1'b0;
            wData_r  <= '0;
            wStrb_r  <= 4'h0;
            wHeld_r  <= 1'b0;
            awReady_r <= 1'b1;
            wReady_r  <= 1'b1;
        end else begin
            if (awTake) begin
                awAddr_r  <= awaddr;
                awHeld_r  <= 1'b1;
                awReady_r <= 1'b0;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end else if (bvalid && bready) begin
                awReady_r <= 1'b1;
            end
            if (wTake) begin
                wData_r  <= wdata;
                wStrb_r  <= wstrb;
                wHeld_r  <= 1'b1;
                wReady_r <= 1'b0;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end else if (bvalid && bready) begin
                wReady_r <= 1'b1;
            end
        end
    end

    // both mode bits clear at reset: normal mode
    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            cfgBits_r <= CFG_RESET[I2S_SERIAL_BIT:I2S_AUDIO_BIT];
        end else if (doWrite && wrHit && wStrb_r[0]) begin
            cfgBits_r <= wData_r[I2S_SERIAL_BIT:I2S_AUDIO_BIT];
        end
    end

    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
            arReady_r <= 1'b1;
        end else if (arTake) begin
            rvalid <= 1'b1;
            arReady_r <= 1'b0;
            rdata  <= rdHit ? cfgWord : '0;
            rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
            arReady_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/apm_pin_router.sv
// module: combinational routing of controller signals to header pins per mode
`timescale 1ns/100ps
`default_nettype none
module apm_pin_router
    import apm_pkg::*;
(
    // mode
    apm_route_if.rtr              route,
    // serial-port controller side
    output var  logic             spiRxData,
    input  wire logic             spiTxData,
    input  wire logic             spiFrame,
    input  wire logic             spiClock,
    // audio-codec controller side
    output var  logic             acRxData,
    input  wire logic             acTxData,
    input  wire logic             acFrame,
    input  wire logic             acClock,
    input  wire logic             acResetN,
    // i2s engine side
    output var  logic             i2sRxData,
    input  wire logic             i2sTxData,
    input  wire logic             i2sFrame,
    input  wire logic             i2sClock,
    input  wire logic             i2sMasterClock,
    // synchronised header inputs
    input  wire logic             syncRxIn,
    input  wire logic             codecRxIn,
    // header outputs
    output var  logic             syncTxOut,
    output var  logic             syncFrameOut,
    output var  logic             syncClockOut,
    output var  logic             codecTxOut,
    output var  logic             codecFrameOut,
    output var  logic             codecClockOut,
    output var  logic             codecResetOut
);
    wire onSerialPins = (route.mode == MODE_I2S_AUDIO);
    wire onAudioPins  = (route.mode == MODE_I2S_SERIAL);

    // serial-port pins: spi, or i2s in audio mode
    assign syncTxOut    = onSerialPins ? i2sTxData : spiTxData;
    assign syncFrameOut = onSerialPins ? i2sFrame  : spiFrame;
    assign syncClockOut = onSerialPins ? i2sClock  : spiClock;
    // audio pins: ac97, or i2s in serial mode
    assign codecTxOut    = onAudioPins ? i2sTxData : acTxData;
    assign codecFrameOut = onAudioPins ? i2sFrame  : acFrame;
    assign codecClockOut = onAudioPins ? i2sClock  : acClock;
    assign codecResetOut = onAudioPins ? i2sMasterClock : acResetN;
    // receive data steering
    assign i2sRxData = onSerialPins ? syncRxIn : (onAudioPins ? codecRxIn : 1'b0);
    assign spiRxData = onSerialPins ? 1'b0 : syncRxIn;
    assign acRxData  = onAudioPins  ? 1'b0 : codecRxIn;
endmodule
`default_nettype wire

// ===== hdl/apm_audio_serial_pin_mux.sv
// module: top of the audio / synchronous serial header pin multiplexer
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - bits 6 and 7 of config select routing
// - normal mode: spi and ac97 on pins
// - audio i2s mode: i2s on serial pins
// - serial i2s mode: i2s on audio pins
// - codec reset pin carries i2s master clock in serial i2s mode
module apm_audio_serial_pin_mux
    import apm_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               codec_reset_n_pin_n,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0]  awaddr,
    input  wire logic               awvalid,
    output var  logic               awready,
    input  wire logic [DATA_W-1:0]  wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output var  logic               wready,
    output var  logic [1:0]         bresp,
    output var  logic               bvalid,
    input  wire logic               bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]  araddr,
    input  wire logic               arvalid,
    output var  logic               arready,
    output var  logic [DATA_W-1:0]  rdata,
    output var  logic [1:0]         rresp,
    output var  logic               rvalid,
    input  wire logic               rready,
    // controller signals
    output var  logic               spiRxData,
    input  wire logic               spiTxData,
    input  wire logic               spiFrame,
    input  wire logic               spiClock,
    output var  logic               acRxData,
    input  wire logic               acTxData,
    input  wire logic               acFrame,
    input  wire logic               acClock,
    input  wire logic               acResetN,
    output var  logic               i2sRxData,
    input  wire logic               i2sTxData,
    input  wire logic               i2sFrame,
    input  wire logic               i2sClock,
    input  wire logic               i2sMasterClock,
    // header pins
    input  wire logic               sync_serial_rx_pin,
    output var  logic               sync_serial_tx_pin,
    output var  logic               sync_serial_frame_pin,
    output var  logic               sync_serial_clock_pin,
    input  wire logic               codec_data_in_pin,
    output var  logic               codec_data_out_pin,
    output var  logic               codec_frame_pin,
    output var  logic               codec_bit_clock_pin,
    output var  logic               codec_reset_n_pin
);
    apm_route_if route ();

    logic [1:0] syncRxMeta_r;
    logic [1:0] codecRxMeta_r;
    logic       spiRx, acRx, i2sRx;
    logic       syncTx, syncFrame, syncClock;
    logic       codecTx, codecFrame, codecClock, codecReset;

    apm_axi_regs u_regs (
        .clk     (clk),
        .codec_reset_n_pin_n  (codec_reset_n_pin_n),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .route   (route)
    );

    apm_pin_router u_router (
        .route          (route),
        .spiRxData      (spiRx),
        .spiTxData      (spiTxData),
        .spiFrame       (spiFrame),
        .spiClock       (spiClock),
        .acRxData       (acRx),
        .acTxData       (acTxData),
        .acFrame        (acFrame),
        .acClock        (acClock),
        .acResetN       (acResetN),
        .i2sRxData      (i2sRx),
        .i2sTxData      (i2sTxData),
        .i2sFrame       (i2sFrame),
        .i2sClock       (i2sClock),
        .i2sMasterClock (i2sMasterClock),
        .syncRxIn       (syncRxMeta_r[1]),
        .codecRxIn      (codecRxMeta_r[1]),
        .syncTxOut      (syncTx),
        .syncFrameOut   (syncFrame),
        .syncClockOut   (syncClock),
        .codecTxOut     (codecTx),
        .codecFrameOut  (codecFrame),
        .codecClockOut  (codecClock),
        .codecResetOut  (codecReset)
    );

    // two-stage synchronisers on header inputs
    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            syncRxMeta_r  <= 2'h0;
            codecRxMeta_r <= 2'h0;
        end else begin
            syncRxMeta_r  <= {syncRxMeta_r[0], sync_serial_rx_pin};
            codecRxMeta_r <= {codecRxMeta_r[0], codec_data_in_pin};
        end
    end

    // registered pin and controller outputs
    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            spiRxData             <= 1'b0;
            acRxData              <= 1'b0;
            i2sRxData             <= 1'b0;
            sync_serial_tx_pin    <= 1'b0;
            sync_serial_frame_pin <= 1'b0;
            sync_serial_clock_pin <= 1'b0;
            codec_data_out_pin    <= 1'b0;
            codec_frame_pin       <= 1'b0;
            codec_bit_clock_pin   <= 1'b0;
            codec_reset_n_pin     <= 1'b0;
        end else begin
            spiRxData             <= spiRx;
            acRxData              <= acRx;
            i2sRxData             <= i2sRx;
            sync_serial_tx_pin    <= syncTx;
            sync_serial_frame_pin <= syncFrame;
            sync_serial_clock_pin <= syncClock;
            codec_data_out_pin    <= codecTx;
            codec_frame_pin       <= codecFrame;
            codec_bit_clock_pin   <= codecClock;
            codec_reset_n_pin     <= codecReset;
        end
    end
endmodule
`default_nettype wire

// ===== test/apm_pin_mux_asserts.sv
// checker: register handshake and header pin routing properties
`timescale 1ns/100ps
`default_nettype none
module apm_pin_mux_asserts
    import apm_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk, codec_reset_n_pin_n, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic        arvalid, arready, rvalid, rready,
    input wire logic [31:0] awaddr, wdata, rdata,
    input wire logic [3:0]  wstrb,
    input wire logic [1:0]  bresp, rresp,
    // routed sources and pins
    input wire logic        acResetN, i2sMasterClock, spiTxData, i2sTxData,
    input wire logic        codec_reset_n_pin, sync_serial_tx_pin
);
    logic [31:0] awAddr_r, wData_r;
    logic        wLane_r, bPrev_r;
    logic [1:0]  mode_r, live_r;
    // tracks the mode as the slave commits it, one cycle behind the register
    always_ff @(posedge clk or negedge codec_reset_n_pin_n) begin
        if (!codec_reset_n_pin_n) begin
            {awAddr_r, wData_r, wLane_r, bPrev_r, mode_r, live_r} <= '0;
        end else begin
            if (awvalid && awready) awAddr_r <= awaddr;
            if (wvalid && wready) {wData_r, wLane_r} <= {wdata, wstrb[0]};
            if (bvalid && !bPrev_r && wLane_r && awAddr_r[31:2] == CFG_ADDR[31:2])
                mode_r <= wData_r[7:6];
            bPrev_r <= bvalid;
            if (!live_r[1]) live_r <= live_r + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!codec_reset_n_pin_n);
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    chk_ar_refused: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
    chk_aw_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_mode_bits: assert property (rvalid |-> rdata == {24'h0, rdata[7:6], 6'h0})
        else $error("read data outside mode bits");
    chk_reset_route: assert property (live_r[1] && mode_r != 2'h2 |->
            codec_reset_n_pin == $past(acResetN))
        else $error("codec reset pin wrong");
    chk_mclk_route: assert property (live_r[1] && mode_r == 2'h2 |->
            codec_reset_n_pin == $past(i2sMasterClock))
        else $error("master clock pin wrong");
    chk_sync_tx: assert property (live_r[1] |-> sync_serial_tx_pin ==
            (mode_r == 2'h1 ? $past(i2sTxData) : $past(spiTxData)))
        else $error("sync tx pin wrong");
endmodule
`default_nettype wire

// ===== test/apm_codec_model.sv
// model: external codec or serial peripheral echoing inverted data
`timescale 1ns/100ps
`default_nettype none
module apm_codec_model (
    input  wire logic clk,
    input  wire logic syncTx,
    input  wire logic codecTx,
    output var  logic syncRx = 1'b0,
    output var  logic codecRx = 1'b0
);
    // answers one clock after the host's data, inverted so stale values show
    always @(posedge clk) begin
        syncRx <= ~syncTx;
        codecRx <= ~codecTx;
    end
endmodule
`default_nettype wire

// ===== test/apm_audio_serial_pin_mux_tb.sv
// testbench: mode register access and header routing of the pin mux
`timescale 1ns/100ps
`default_nettype none
module apm_audio_serial_pin_mux_tb
    import apm_pkg::*;
;
    logic        clk, codec_reset_n_pin_n, awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [10:0] ctl;
    logic        awready, wready, bvalid, arready, rvalid, spiRxData, acRxData, i2sRxData;
    logic        sync_serial_rx_pin, sync_serial_tx_pin, sync_serial_frame_pin;
    logic        sync_serial_clock_pin, codec_data_in_pin, codec_data_out_pin;
    logic        codec_frame_pin, codec_bit_clock_pin, codec_reset_n_pin;
    int          errCount, numChecks, i, j, n, lag;
    wire logic [9:0] pins = {sync_serial_tx_pin, sync_serial_frame_pin, sync_serial_clock_pin,
        codec_data_out_pin, codec_frame_pin, codec_bit_clock_pin, codec_reset_n_pin,
        spiRxData, acRxData, i2sRxData};
    apm_audio_serial_pin_mux i_apm_audio_serial_pin_mux (.clk, .codec_reset_n_pin_n, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .spiRxData, .acRxData,
        .i2sRxData, .spiTxData(ctl[10]), .spiFrame(ctl[9]), .spiClock(ctl[8]),
        .acTxData(ctl[7]), .acFrame(ctl[6]), .acClock(ctl[5]), .acResetN(ctl[4]),
        .i2sTxData(ctl[3]), .i2sFrame(ctl[2]), .i2sClock(ctl[1]), .i2sMasterClock(ctl[0]),
        .sync_serial_rx_pin, .sync_serial_tx_pin, .sync_serial_frame_pin,
        .sync_serial_clock_pin, .codec_data_in_pin, .codec_data_out_pin, .codec_frame_pin,
        .codec_bit_clock_pin, .codec_reset_n_pin);
    apm_codec_model i_apm_codec_model (.clk, .syncTx(sync_serial_tx_pin),
        .codecTx(codec_data_out_pin), .syncRx(sync_serial_rx_pin), .codecRx(codec_data_in_pin));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %0t bus got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pins(input logic [9:0] got, input logic [9:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %0t pins got %b want %b", $time, got, exp);
        end
    endtask
    task automatic timeout_chk();
        if (n == 64) begin
            errCount++;
            $display("BAD %0t bus wait ran out", $time);
            results();
        end
    endtask
    task automatic axw(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        @(posedge clk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 2'h3, lag == 0};
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (n + 1 == lag) bready <= 1'b1;
        end
        bready <= 1'b0;
        timeout_chk();
        cmp_bus(32'(bresp), 32'(er));
    endtask
    task automatic axr(input logic [31:0] a, ed, input logic [1:0] er);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 1'b1, lag == 0};
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (n + 1 == lag) rready <= 1'b1;
        end
        rready <= 1'b0;
        timeout_chk();
        cmp_bus(rdata, ed);
        cmp_bus(32'(rresp), 32'(er));
    endtask
    // pin outputs then controller rx levels, given the loopback partner
    function automatic logic [9:0] exp_pins(input logic [1:0] m, input logic [10:0] c);
        logic [6:0] e;
        e[6:4] = (m == 2'h1) ? c[3:1] : c[10:8];
        e[3:0] = (m == 2'h2) ? c[3:0] : c[7:4];
        return {e, (m == 2'h1) ? 1'b0 : ~e[6], (m == 2'h2) ? 1'b0 : ~e[3],
                (m == 2'h1) ? ~e[6] : (m == 2'h2) ? ~e[3] : 1'b0};
    endfunction
    initial begin
        codec_reset_n_pin_n <= 1'b0;
        {awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} <= '0;
        ctl <= 11'h5A5;
        repeat (8) @(posedge clk);
        codec_reset_n_pin_n <= 1'b1;
        axr(CFG_ADDR, 32'h0, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            axw(CFG_ADDR, {24'hFF_FFFF, i[1:0], 6'h3F}, 4'hF, RESP_OKAY);
            axr(CFG_ADDR, {24'h0, i[1:0], 6'h0}, RESP_OKAY);
            for (j = 0; j < 2; j++) begin
                ctl <= ~ctl;
                repeat (8) @(posedge clk);
                cmp_pins(pins, exp_pins(i[1:0], ctl));
            end
        end
        // late ready from here on, so the slave must hold its answers
        lag = 4;
        axw(CFG_ADDR, 32'h40, 4'hE, RESP_OKAY);
        axr(CFG_ADDR, 32'hC0, RESP_OKAY);
        axw(CFG_ADDR + 32'h4, 32'h80, 4'hF, RESP_SLVERR);
        axr(CFG_ADDR + 32'h4, 32'h0, RESP_SLVERR);
        @(posedge clk);
        codec_reset_n_pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        codec_reset_n_pin_n <= 1'b1;
        axr(CFG_ADDR, 32'h0, RESP_OKAY);
        results();
    end
endmodule
bind apm_audio_serial_pin_mux apm_pin_mux_asserts i_chk (.clk, .codec_reset_n_pin_n, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .awaddr, .wdata,
    .rdata, .wstrb, .bresp, .rresp, .acResetN, .i2sMasterClock, .spiTxData, .i2sTxData,
    .codec_reset_n_pin, .sync_serial_tx_pin);
`default_nettype wire
